/* gear_pkg.sv */
// Shared constants of the gearing and pulse command port
package gear_pkg;
    // Clock and link rates
    localparam int CLK_HZ         = 50_000_000;
    localparam int DIFF_IN_MAX_HZ = 3_000_000;
    localparam int OPTO_IN_MAX_HZ = 500_000;
    localparam int EMU_OUT_MAX_HZ = 3_000_000;
    // Least emulated edge spacing in whole cycles
    localparam int QUAD_GAP_CYC   =
        (CLK_HZ + 4 * EMU_OUT_MAX_HZ - 1) / (4 * EMU_OUT_MAX_HZ);
    localparam int PULSE_GAP_CYC  =
        (CLK_HZ + 2 * EMU_OUT_MAX_HZ - 1) / (2 * EMU_OUT_MAX_HZ);
    // Opto snapshot period
    localparam int OPTO_POLL_US   = 250;
    localparam int OPTO_POLL_CYC  = OPTO_POLL_US * (CLK_HZ / 1_000_000);

    // Register byte offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_EMU_PPR   = 8'h04;
    localparam logic [7:0] REG_GEAR      = 8'h08;
    localparam logic [7:0] REG_CMD_POS   = 8'h0C;
    localparam logic [7:0] REG_OPTO_SNAP = 8'h10;
    localparam logic [7:0] REG_ABS_POS   = 8'h14;
    localparam logic [7:0] REG_ABS_CMD   = 8'h18;
    localparam logic [7:0] REG_STATUS    = 8'h1C;
    localparam logic [7:0] REG_INDEX_POS = 8'h20;

    // Control field positions
    localparam int CTRL_SECONDARY_FEEDBACK_MODE_LSB = 0;
    localparam int CTRL_FB2_SRC_LSB  = 2;
    localparam int CTRL_THIRD_FEEDBACK_MODE_LSB = 4;
    localparam int CTRL_EMU_MODE_LSB = 8;

    // Reset values
    localparam logic [15:0] PPR_RESET      = 16'h0400;
    localparam logic [15:0] GEAR_NUM_RESET = 16'h0001;
    localparam logic [15:0] GEAR_DEN_RESET = 16'h0001;
    localparam logic [1:0]  FB2_SRC_RESET  = 2'h0;
    localparam logic [1:0]  THIRD_FEEDBACK_MODE_RESET = 2'h1;
    localparam logic [7:0]  ABS_CMD_RESET  = 8'h07;

    // Input pulse formats
    localparam logic [1:0] FMT_QUAD  = 2'h0;
    localparam logic [1:0] FMT_PDIR  = 2'h1;
    localparam logic [1:0] FMT_CWCCW = 2'h2;

    // Secondary feedback sources
    localparam logic [1:0] SRC_DIFF = 2'h1;
    localparam logic [1:0] SRC_OPTO = 2'h2;

    // Third feedback mode of the absolute link
    localparam logic [1:0] FB3_ABS = 2'h0;

    // Emulation port modes
    localparam logic [3:0] EMU_INPUT = 4'h0;
    localparam logic [3:0] EMU_QUAD  = 4'h1;
    localparam logic [3:0] EMU_PDIR  = 4'h2;
    localparam logic [3:0] EMU_CWCCW = 4'h3;
    localparam logic [3:0] EMU_ABS   = 4'hB;

    // Absolute link frame shape
    localparam int ABS_GAP_TICKS = 4;
endpackage

/* pulse_decoder.sv */
// Pulse, CW/CCW and quadrature decoder with count strobes
module pulse_decoder (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       en_i,
    input  wire logic [1:0] fmt_i,
    input  wire logic       a_i,
    input  wire logic       b_i,
    output logic            up_o,
    output logic            down_o
);
    logic prev_a;
    logic prev_b;
    logic chg_a;
    logic chg_b;
    logic rise_a;
    logic rise_b;

    assign chg_a  = a_i ^ prev_a;
    assign chg_b  = b_i ^ prev_b;
    assign rise_a = a_i & ~prev_a;
    assign rise_b = b_i & ~prev_b;

    // Tracked while disabled so enabling gives no step
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            prev_a <= a_i;
            prev_b <= b_i;
        end
    end

    // Count strobes per format
    always_ff @(posedge mclk_i) begin
        if (srst_i || !en_i) begin
            up_o   <= 1'b0;
            down_o <= 1'b0;
        end else begin
            up_o   <= 1'b0;
            down_o <= 1'b0;
            case (fmt_i)
                gear_pkg::FMT_QUAD: begin
                    // Double changes are skipped
                    if (chg_a ^ chg_b) begin
                        up_o   <= a_i ^ prev_b;
                        down_o <= ~(a_i ^ prev_b);
                    end
                end
                gear_pkg::FMT_PDIR: begin
                    // Direction low counts up, high counts down
                    if (rise_a) begin
                        up_o   <= ~b_i;
                        down_o <= b_i;
                    end
                end
                gear_pkg::FMT_CWCCW: begin
                    // Simultaneous edges cancel
                    up_o   <= rise_a & ~rise_b;
                    down_o <= rise_b & ~rise_a;
                end
                default: begin
                    up_o   <= 1'b0;
                    down_o <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* gearing_pulse_port.sv */
// Gearing port: command decode, scaling, encoder emulation, absolute link
//
// What this block does
// - Differential port is input or output; only the absolute link drives A while reading B.
// - Differential input: pulse/dir, CW/CCW, quadrature or absolute link.
// - Differential output emulates pulse/dir, CW/CCW or quadrature.
// - Opto pair decodes the three pulse formats; no output mode.
// - Opto pair counts up to 500 kHz; source stays below.
// - Opto count and levels snapshot every 250 us.
// - Differential input decodes up to 3 MHz; source stays below.
// - Each emulated channel toggles at most 3 MHz.
// - Emulated pulses per revolution are programmable.
// - Emulated B lags or leads A by a quarter period.
// - Every output mode also drives index.
// - Mode 0, source 1: quadrature on the differential port.
// - Mode 0, source 2: quadrature on the opto pair.
// - Third mode 0, emulation mode 11: absolute link.
// - Command pulse to motion scaling is adjustable.
// - Emulation follows primary position; one index per revolution.
//
// Chosen here: the address map and strobed register access.
module gearing_pulse_port #(
    parameter int PW            = 16,
    parameter int ABS_BITS      = 24,
    parameter int ABS_CMD_BITS  = 8,
    parameter int ABS_HALF      = 10,
    parameter int OPTO_POLL_CYC = gear_pkg::OPTO_POLL_CYC
) (
    input  wire logic                mclk_i,
    input  wire logic                srst_i,
    input  wire logic [7:0]          addr_i,
    input  wire logic [31:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [31:0]         rdata_o,
    input  wire logic [PW-1:0]       pos_i,
    input  wire logic                diff_a_i,
    output logic                     diff_a_o,
    output logic                     diff_a_oe_o,
    input  wire logic                diff_b_i,
    output logic                     diff_b_o,
    output logic                     diff_b_oe_o,
    input  wire logic                diff_z_i,
    output logic                     diff_z_o,
    output logic                     diff_z_oe_o,
    input  wire logic                opto_a_i,
    input  wire logic                opto_b_i,
    output logic      [31:0]         cmd_pos_o,
    output logic      [ABS_BITS-1:0] abs_pos_o,
    output logic                     abs_valid_o
);
    typedef enum logic [1:0] {ABS_IDLE, ABS_SEND, ABS_RECV, ABS_GAP}
        abs_state_t;

    // Modular up/down step; returns {wrapped, value}
    function automatic logic [18:0] mod_move(input logic [17:0] v,
                                             input logic [17:0] d,
                                             input logic [17:0] m,
                                             input logic        up);
        logic [18:0] s;
        s = 19'h00000;
        if (up) begin
            s = {1'b0, v} + {1'b0, d};
            if (s >= {1'b0, m})
                s = {1'b1, 18'(s[17:0] - m)};
        end else if (v >= d) begin
            s = {1'b0, 18'(v - d)};
        end else begin
            s = {1'b1, 18'(v + m - d)};
        end
        return s;
    endfunction

    // Configuration
    logic [1:0]  secondary_feedback_mode;
    logic [1:0]  secondary_feedback_source;
    logic [1:0]  third_feedback_mode;
    logic [3:0]  emulation_port_mode;
    logic [15:0] emu_ppr;
    logic [15:0] gear_num;
    logic [15:0] gear_den;
    logic [7:0]  abs_cmd;

    // Mode decode
    logic port_out;
    logic abs_sel;
    logic in_diff;
    logic in_opto;
    assign port_out = emulation_port_mode == gear_pkg::EMU_QUAD
                   || emulation_port_mode == gear_pkg::EMU_PDIR
                   || emulation_port_mode == gear_pkg::EMU_CWCCW;
    assign abs_sel  = !port_out
                   && third_feedback_mode == gear_pkg::FB3_ABS
                   && emulation_port_mode == gear_pkg::EMU_ABS;
    assign in_diff  = !port_out && !abs_sel
                   && secondary_feedback_source == gear_pkg::SRC_DIFF;
    assign in_opto  = secondary_feedback_source == gear_pkg::SRC_OPTO;

    // Register writes
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            secondary_feedback_mode   <= gear_pkg::FMT_QUAD;
            secondary_feedback_source <= gear_pkg::FB2_SRC_RESET;
            third_feedback_mode       <= gear_pkg::THIRD_FEEDBACK_MODE_RESET;
            emulation_port_mode       <= gear_pkg::EMU_INPUT;
            emu_ppr                   <= gear_pkg::PPR_RESET;
            gear_num                  <= gear_pkg::GEAR_NUM_RESET;
            gear_den                  <= gear_pkg::GEAR_DEN_RESET;
            abs_cmd                   <= gear_pkg::ABS_CMD_RESET;
        end else if (wr_i) begin
            case (addr_i)
                gear_pkg::REG_CTRL: begin
                    secondary_feedback_mode   <=
                        wdata_i[gear_pkg::CTRL_SECONDARY_FEEDBACK_MODE_LSB +: 2];
                    secondary_feedback_source <=
                        wdata_i[gear_pkg::CTRL_FB2_SRC_LSB +: 2];
                    third_feedback_mode       <=
                        wdata_i[gear_pkg::CTRL_THIRD_FEEDBACK_MODE_LSB +: 2];
                    emulation_port_mode       <=
                        wdata_i[gear_pkg::CTRL_EMU_MODE_LSB +: 4];
                end
                gear_pkg::REG_EMU_PPR: emu_ppr <= wdata_i[15:0];
                gear_pkg::REG_GEAR: begin
                    gear_num <= wdata_i[15:0];
                    gear_den <= wdata_i[31:16];
                end
                gear_pkg::REG_ABS_CMD: abs_cmd <= wdata_i[7:0];
                default: begin
                end
            endcase
        end
    end

    // Decoders; opto feeds only counting
    logic diff_up;
    logic diff_down;
    logic opto_up;
    logic opto_down;

    pulse_decoder u_diff_dec (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .en_i   (in_diff),
        .fmt_i  (secondary_feedback_mode),
        .a_i    (diff_a_i),
        .b_i    (diff_b_i),
        .up_o   (diff_up),
        .down_o (diff_down)
    );

    pulse_decoder u_opto_dec (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .en_i   (in_opto),
        .fmt_i  (secondary_feedback_mode),
        .a_i    (opto_a_i),
        .b_i    (opto_b_i),
        .up_o   (opto_up),
        .down_o (opto_down)
    );

    // Scaled command position; gear_num must not exceed gear_den
    logic [17:0] gear_acc;
    logic [18:0] gear_nxt;
    logic        step_up;
    logic        step_dn;
    assign step_up  = diff_up | opto_up;
    assign step_dn  = diff_down | opto_down;
    assign gear_nxt = mod_move(gear_acc, {2'h0, gear_num},
                               {2'h0, gear_den}, step_up);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            gear_acc  <= 18'h00000;
            cmd_pos_o <= 32'h00000000;
        end else if ((step_up || step_dn) && gear_den != 16'h0000) begin
            gear_acc <= gear_nxt[17:0];
            if (gear_nxt[18])
                cmd_pos_o <= step_up ? cmd_pos_o + 32'h1
                                     : cmd_pos_o - 32'h1;
        end
    end

    // Latch command position on index edge
    logic        prev_z;
    logic [31:0] index_pos;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prev_z    <= 1'b0;
            index_pos <= 32'h00000000;
        end else begin
            prev_z <= diff_z_i;
            if (in_diff && diff_z_i && !prev_z)
                index_pos <= cmd_pos_o;
        end
    end

    // Raw opto count, snapshot at a fixed period
    logic [15:0] opto_cnt;
    logic [17:0] opto_snap;
    logic [31:0] poll_cnt;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            opto_cnt  <= 16'h0000;
            opto_snap <= 18'h00000;
            poll_cnt  <= 32'h00000000;
        end else begin
            if (opto_up)
                opto_cnt <= opto_cnt + 16'h1;
            else if (opto_down)
                opto_cnt <= opto_cnt - 16'h1;
            if (poll_cnt == 32'(OPTO_POLL_CYC - 1)) begin
                poll_cnt  <= 32'h00000000;
                opto_snap <= {opto_b_i, opto_a_i, opto_cnt};
            end else begin
                poll_cnt <= poll_cnt + 32'h1;
            end
        end
    end

    // Emulation target from primary mechanical position
    logic [PW-1:0] pos_q;
    logic [31:0]   prod;
    logic          quad_out;
    logic [17:0]   spr;
    logic [17:0]   target;
    logic [17:0]   cur;
    logic [17:0]   fwd;
    logic [18:0]   cur_nxt;
    logic          emu_up;
    assign quad_out = emulation_port_mode == gear_pkg::EMU_QUAD;
    assign prod     = 32'(pos_q) * {16'h0000, emu_ppr};
    assign spr      = quad_out ? {emu_ppr, 2'b00} : {1'b0, emu_ppr, 1'b0};
    // Scale to steps per revolution: four per line or two per pulse
    assign target   = quad_out ? 18'(prod >> (PW - 2))
                               : 18'(prod >> (PW - 1));
    assign fwd      = target >= cur ? 18'(target - cur)
                                    : 18'(target + spr - cur);
    // Shorter way round the revolution
    assign emu_up   = fwd < {1'b0, spr[17:1]};
    assign cur_nxt  = mod_move(cur, 18'h00001, spr, emu_up);

    logic [3:0] gap_cnt;
    logic [1:0] phase;
    logic       tog_cw;
    logic       tog_ccw;
    logic       emu_dir;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pos_q   <= '0;
            cur     <= 18'h00000;
            gap_cnt <= 4'h0;
            phase   <= 2'h0;
            tog_cw  <= 1'b0;
            tog_ccw <= 1'b0;
            emu_dir <= 1'b0;
        end else begin
            pos_q <= pos_i;
            if (!port_out || emu_ppr == 16'h0000) begin
                cur     <= 18'h00000;
                gap_cnt <= 4'(gear_pkg::PULSE_GAP_CYC - 1);
            end else if (gap_cnt != 4'h0) begin
                gap_cnt <= gap_cnt - 4'h1;
            end else if (target != cur && target < spr) begin
                // Rate limit: a lagging follower catches up later
                gap_cnt <= quad_out ? 4'(gear_pkg::QUAD_GAP_CYC - 1)
                                    : 4'(gear_pkg::PULSE_GAP_CYC - 1);
                cur     <= cur_nxt[17:0];
                phase   <= emu_up ? phase + 2'h1 : phase - 2'h1;
                emu_dir <= ~emu_up;
                if (emu_up)
                    tog_cw <= ~tog_cw;
                else
                    tog_ccw <= ~tog_ccw;
            end
        end
    end

    // Absolute link: device clocks, data turns round after command
    abs_state_t  abs_state;
    logic [15:0] half_cnt;
    logic [7:0]  bit_cnt;
    logic        abs_clk;
    logic        abs_dout;
    logic        abs_drive;
    logic [7:0]  cmd_sh;
    logic [ABS_BITS-1:0] rx_sh;
    logic        tick;
    assign tick = half_cnt == 16'(ABS_HALF - 1);

    always_ff @(posedge mclk_i) begin
        if (srst_i || !abs_sel) begin
            abs_state <= ABS_IDLE;
            half_cnt  <= 16'h0000;
            bit_cnt   <= 8'h00;
            abs_clk   <= 1'b1;
            abs_dout  <= 1'b1;
            abs_drive <= 1'b0;
            cmd_sh    <= 8'h00;
            rx_sh     <= '0;
        end else begin
            half_cnt <= tick ? 16'h0000 : half_cnt + 16'h1;
            case (abs_state)
                ABS_IDLE: begin
                    if (tick) begin
                        abs_state <= ABS_SEND;
                        abs_drive <= 1'b1;
                        cmd_sh    <= abs_cmd;
                        bit_cnt   <= 8'h00;
                    end
                end
                ABS_SEND: begin
                    if (tick) begin
                        abs_clk <= ~abs_clk;
                        if (abs_clk) begin
                            // Data changes while clock falls
                            abs_dout <= cmd_sh[ABS_CMD_BITS-1];
                            cmd_sh   <= cmd_sh << 1;
                        end else if (bit_cnt == 8'(ABS_CMD_BITS - 1)) begin
                            abs_state <= ABS_RECV;
                            abs_drive <= 1'b0;
                            bit_cnt   <= 8'h00;
                        end else begin
                            bit_cnt <= bit_cnt + 8'h1;
                        end
                    end
                end
                ABS_RECV: begin
                    if (tick) begin
                        abs_clk <= ~abs_clk;
                        if (!abs_clk) begin
                            rx_sh <= {rx_sh[ABS_BITS-2:0], diff_b_i};
                            if (bit_cnt == 8'(ABS_BITS - 1)) begin
                                abs_state <= ABS_GAP;
                                bit_cnt   <= 8'h00;
                            end else begin
                                bit_cnt <= bit_cnt + 8'h1;
                            end
                        end
                    end
                end
                ABS_GAP: begin
                    abs_clk <= 1'b1;
                    if (tick) begin
                        if (bit_cnt == 8'(gear_pkg::ABS_GAP_TICKS - 1))
                            abs_state <= ABS_IDLE;
                        bit_cnt <= bit_cnt + 8'h1;
                    end
                end
                default: abs_state <= ABS_IDLE;
            endcase
        end
    end

    // Word taken at frame close
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            abs_pos_o   <= '0;
            abs_valid_o <= 1'b0;
        end else if (!abs_sel) begin
            abs_valid_o <= 1'b0;
        end else if (abs_state == ABS_GAP && bit_cnt == 8'h00 && tick) begin
            abs_pos_o   <= rx_sh;
            abs_valid_o <= 1'b1;
        end
    end

    // Pin drivers, enables low in input modes except the absolute link: A always, B while the command is sent
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            diff_a_o    <= 1'b0;
            diff_b_o    <= 1'b0;
            diff_z_o    <= 1'b0;
            diff_a_oe_o <= 1'b0;
            diff_b_oe_o <= 1'b0;
            diff_z_oe_o <= 1'b0;
        end else begin
            diff_a_oe_o <= port_out | abs_sel;
            diff_b_oe_o <= port_out | (abs_sel & abs_drive);
            diff_z_oe_o <= port_out;
            diff_z_o    <= port_out && cur == 18'h00000;
            case (emulation_port_mode)
                gear_pkg::EMU_QUAD: begin
                    diff_a_o <= phase[1];
                    diff_b_o <= phase[1] ^ phase[0];
                end
                gear_pkg::EMU_PDIR: begin
                    diff_a_o <= phase[0];
                    diff_b_o <= emu_dir;
                end
                gear_pkg::EMU_CWCCW: begin
                    diff_a_o <= tog_cw;
                    diff_b_o <= tog_ccw;
                end
                default: begin
                    diff_a_o <= abs_clk;
                    diff_b_o <= abs_dout;
                end
            endcase
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (srst_i || !rd_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            case (addr_i)
                gear_pkg::REG_CTRL: rdata_o <= {20'h00000,
                    emulation_port_mode, 2'h0, third_feedback_mode,
                    secondary_feedback_source, secondary_feedback_mode};
                gear_pkg::REG_EMU_PPR:   rdata_o <= {16'h0000, emu_ppr};
                gear_pkg::REG_GEAR:      rdata_o <= {gear_den, gear_num};
                gear_pkg::REG_CMD_POS:   rdata_o <= cmd_pos_o;
                gear_pkg::REG_OPTO_SNAP: rdata_o <= {14'h0000, opto_snap};
                gear_pkg::REG_ABS_POS:   rdata_o <= 32'(abs_pos_o);
                gear_pkg::REG_ABS_CMD:   rdata_o <= {24'h000000, abs_cmd};
                gear_pkg::REG_STATUS:    rdata_o <= {28'h0000000,
                    abs_valid_o, in_diff | in_opto, abs_sel, port_out};
                gear_pkg::REG_INDEX_POS: rdata_o <= index_pos;
                default:                 rdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule

/* gearing_pulse_port_props.sv */
// Port assertions of the gearing pulse port
module gearing_pulse_port_props (
    input wire logic        mclk_i,
    input wire logic        srst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        diff_a_o,
    input wire logic        diff_a_oe_o,
    input wire logic        diff_b_o,
    input wire logic        diff_b_oe_o,
    input wire logic [31:0] cmd_pos_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // Pulse count written then read back
    sequence s_wr; wr_i && addr_i == gear_pkg::REG_EMU_PPR; endsequence
    sequence s_rd; rd_i && addr_i == gear_pkg::REG_EMU_PPR; endsequence
    property p_ppr;
        s_wr ##1 s_rd |=> rdata_o[15:0] == $past(wdata_i[15:0], 2);
    endproperty
    a_ppr: assert property (p_ppr) else $error("ppr readback");
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_unmap; rd_i && addr_i > 8'h20 |=> rdata_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    // Position moves one unit at a time
    property p_step;
        $changed(cmd_pos_o) |->
            cmd_pos_o - $past(cmd_pos_o) inside {32'h1, 32'hFFFFFFFF};
    endproperty
    a_step: assert property (p_step) else $error("cmd jump");
    // Emulated edges keep the top rate
    property p_a_gap;
        diff_a_oe_o && $changed(diff_a_o) |=>
            (!diff_a_oe_o || $stable(diff_a_o)) [*4];
    endproperty
    a_a_gap: assert property (p_a_gap) else $error("A too fast");
    property p_b_gap;
        diff_b_oe_o && $changed(diff_b_o) |=>
            (!diff_b_oe_o || $stable(diff_b_o)) [*4];
    endproperty
    a_b_gap: assert property (p_b_gap) else $error("B too fast");
    property p_rst;
        disable iff (1'b0) srst_i |=> !diff_a_oe_o && cmd_pos_o == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not quiet");
    property p_ro;
        wr_i && addr_i == gear_pkg::REG_CMD_POS |=> $stable(cmd_pos_o);
    endproperty
    a_ro: assert property (p_ro) else $error("ro write took");
    property p_oe; !diff_a_oe_o |-> !diff_b_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("B driven alone");
endmodule

/* pulse_source.sv */
// Far side pulse source: stepper control or encoder
module pulse_source #(
    parameter int GAP = 50
) (
    input  wire logic mclk_i,
    output logic      a_o,
    output logic      b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph;
    // Lines idle low until the first command
    initial begin
        ph = 2'h0;
        a_o = 1'b0;
        b_o = 1'b0;
    end
    // One count per call; GAP keeps edges under the input rate
    // Used as a command source; the held B line of src_d also feeds the absolute link data
    task automatic step(input logic [1:0] fmt, input logic up);
        if (fmt == gear_pkg::FMT_QUAD) begin
            ph = up ? ph + 2'h1 : ph - 2'h1;
            a_o <= ph[1] ^ ph[0];
            b_o <= ph[1];
        end else begin
            a_o <= 1'b0;
            b_o <= fmt == gear_pkg::FMT_PDIR && !up;
            repeat (GAP) @(posedge mclk_i);
            if (fmt == gear_pkg::FMT_PDIR || up) a_o <= 1'b1;
            else b_o <= 1'b1;
            repeat (GAP) @(posedge mclk_i);
            a_o <= 1'b0;
            b_o <= fmt == gear_pkg::FMT_PDIR && !up;
        end
        repeat (GAP) @(posedge mclk_i);
    endtask
endmodule

/* test_gearing_pulse_port.sv */
// Testbench of the gearing pulse port
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module test_gearing_pulse_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] pos_i = 16'h0;
    logic [31:0] rdata_o, cmd_pos_o;
    logic [23:0] abs_pos_o;
    logic        abs_valid_o, a_o, a_oe, b_o, b_oe, z_o, z_oe, da, db, oa, ob;
    int          err_total = 0;
    int          num_checks = 0;
    logic [1:0]  fm [3] = '{gear_pkg::FMT_QUAD, gear_pkg::FMT_PDIR,
                            gear_pkg::FMT_CWCCW};
    always #10 mclk_i = ~mclk_i;
    // Far side drives diff lines while the port listens
    pulse_source #(.GAP(5)) src_d (.mclk_i, .a_o(da), .b_o(db));
    pulse_source #(.GAP(50)) src_o (.mclk_i, .a_o(oa), .b_o(ob));
    gearing_pulse_port #(.ABS_HALF(6), .OPTO_POLL_CYC(20)) DUT (
        .mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pos_i,
        .diff_a_i(a_oe ? a_o : da), .diff_a_o(a_o), .diff_a_oe_o(a_oe),
        .diff_b_i(b_oe ? b_o : db), .diff_b_o(b_o), .diff_b_oe_o(b_oe),
        .diff_z_i(1'b0), .diff_z_o(z_o), .diff_z_oe_o(z_oe), .opto_a_i(oa),
        .opto_b_i(ob), .cmd_pos_o, .abs_pos_o, .abs_valid_o);
    // Register bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i) `CHK(rdata_o, e)
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog far past the test length
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        final_report();
    end
    // Test sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        rd(gear_pkg::REG_CTRL, 32'h10);
        rd(gear_pkg::REG_GEAR, 32'h10001);
        rd(gear_pkg::REG_ABS_CMD, 32'h7);
        rd(8'h24, 32'h0);
        $display("register test done");
        wr(gear_pkg::REG_CTRL, 32'h14);
        for (int i = 0; i < 4; i++) src_d.step(gear_pkg::FMT_QUAD, i != 3);
        wr(gear_pkg::REG_CMD_POS, 32'hFF);
        rd(gear_pkg::REG_CMD_POS, 32'h2);
        $display("diff count test done");
        foreach (fm[k]) begin
            wr(gear_pkg::REG_CTRL, {26'h0, 2'h1, 2'h2, fm[k]});
            for (int i = 0; i < 3; i++) src_o.step(fm[k], i != 2);
            `CHK(cmd_pos_o, 32'(3 + k))
        end
        wr(gear_pkg::REG_GEAR, 32'h00020001);
        repeat (2) src_o.step(gear_pkg::FMT_CWCCW, 1'b1);
        `CHK(cmd_pos_o, 32'h6)
        rd(gear_pkg::REG_OPTO_SNAP, 32'h5);
        $display("opto count test done");
        wr(gear_pkg::REG_EMU_PPR, 32'h4);
        rd(gear_pkg::REG_EMU_PPR, 32'h4);
        pos_i <= 16'h3000;
        wr(gear_pkg::REG_CTRL, 32'h110);
        repeat (60) @(posedge mclk_i);
        `CHK({a_oe, a_o, b_o, z_oe, z_o}, 5'h1A)
        pos_i <= 16'h0;
        repeat (60) @(posedge mclk_i);
        for (int m = 1; m < 4; m++) begin
            wr(gear_pkg::REG_CTRL, {20'h0, 4'(m), 8'h10});
            repeat (20) @(posedge mclk_i);
            `CHK({b_oe, z_oe, z_o}, 3'h7)
            wr(gear_pkg::REG_CTRL, 32'h10);
            repeat (20) @(posedge mclk_i);
            `CHK(a_oe, 1'b0)
        end
        $display("emulation test done");
        wr(gear_pkg::REG_CTRL, 32'hB00);
        repeat (700) @(posedge mclk_i);
        `CHK({abs_valid_o, abs_pos_o}, 25'h1FFFFFF)
        $display("abs link test done");
        final_report();
    end
endmodule
bind gearing_pulse_port gearing_pulse_port_props u_props (.mclk_i, .srst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .diff_a_o, .diff_a_oe_o,
    .diff_b_o, .diff_b_oe_o, .cmd_pos_o);
